// [core/irq_vector_consts.vh]
`ifndef IRQ_VECTOR_CONSTS_VH
`define IRQ_VECTOR_CONSTS_VH
// fixed vector low addresses (20-bit)
`define VEC_UNDEF 20'hFFFDC
`define VEC_OVFL 20'hFFFE0
`define VEC_BREAK 20'hFFFE4
`define VEC_ADDR_MATCH 20'hFFFE8
`define VEC_STEP 20'hFFFEC
`define VEC_WDOG 20'hFFFF0
`define VEC_DEBUG 20'hFFFF4
`define VEC_NMI 20'hFFFF8
`define VEC_RESET 20'hFFFFC
`define VEC_FIXED_BASE 20'hFFFDC
// break vector content that redirects to variable entry 0
`define BREAK_REDIRECT 8'hFF
// variable table
`define VAR_SPAN 9'h100
`define VAR_PERIPH_LAST 6'h1F
`define VAR_SOFT_LAST 6'h3F
// peripheral entry numbers
`define ENT_BREAK 5'h00
`define ENT_EXT3 5'h04
`define ENT_EXT5 5'h08
`define ENT_EXT4 5'h09
`define ENT_BUS_COLL 5'h0A
`define ENT_DMA0 5'h0B
`define ENT_DMA1 5'h0C
`define ENT_KEY 5'h0D
`define ENT_ADC 5'h0E
`define ENT_SER_FIRST 5'h0F
`define ENT_TA_FIRST 5'h15
`define ENT_TB_FIRST 5'h1A
`define ENT_EXT0 5'h1D
`define ENT_EXT1 5'h1E
// reserved entries carry no source
`define RESERVED_MASK 32'h800000E1
// edge select codes and disabled priority level
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_BOTH 2'h2
`define LEVEL_OFF 3'h0
`endif

// [core/ext_edge_detect.v]
`timescale 1ns/100ps
`include "irq_vector_consts.vh"
module ext_edge_detect (
	// clock and reset
	input wire mclk,
	input wire arst_n,
	// pin and selection
	input wire pin,
	input wire [1:0] edge_sel,
	// one-cycle event
	output reg hit
);
	reg last;
	wire rise;
	wire fall;
	assign rise = pin & ~last;
	assign fall = ~pin & last;
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			last <= 1'b0;
			hit <= 1'b0;
		end else begin
			last <= pin;
			case (edge_sel)
			`EDGE_FALL: begin
				hit <= fall;
			end
			`EDGE_RISE: begin
				hit <= rise;
			end
			`EDGE_BOTH: begin
				hit <= rise | fall;
			end
			default: begin
				hit <= 1'b0;
			end
			endcase
		end
	end
endmodule

// [core/interrupt_vectoring_unit.v]
// Contract
// - maskables gated by enable and priority; others not
// - instruction interrupts never masked by enable or priority level
// - undefined opcode vectors at fixed FFFDC
// - overflow trap only when overflow flag set
// - break vector FF redirects to variable entry 0
// - numbered interrupts 0-63; 0-31 share peripheral vectors
// - numbers 0-31 save and clear stack select
// - numbers 32-63 leave stack select alone
// - reset pin low vectors at FFFFC
// - enabled nmi pin low vectors at FFFF8
// - debug break at FFFF4, debugger only
// - debug flag: single step after each instruction
// - address match before first-address instruction at FFFE8
// - watchdog, oscillator, voltage share FFFF0
// - fixed vectors four bytes from FFFDC upward
// - variable entry n at base plus 4n
// - peripherals maskable through entries 0 to 31
// - entries 4,8-14 pins, collision, dma, key, adc
// - 15-20 serial, 21-25 A, 26-28 B, 29-30 pins
// - entries 32-63 unmaskable software only
// - key pin low raises key interrupt
// - external pins trigger on selected edges
// - accept if enable, request, level above cpu level
// - hardware sets request, clears on accept; software clears
// - three-bit level per source, zero disables
`timescale 1ns/100ps
`include "irq_vector_consts.vh"
module interrupt_vectoring_unit (
	// clock and reset
	input wire mclk,
	input wire arst_n,
	// cpu flags and state
	input wire global_irq_enable,
	input wire overflow_flag,
	input wire debug_flag,
	input wire stack_select_flag,
	input wire [2:0] cpu_priority_level,
	input wire [19:0] vector_base_reg,
	// instruction events (one cycle each)
	input wire undefined_opcode_instr,
	input wire overflow_trap_instr,
	input wire break_instr,
	input wire soft_int_instr,
	input wire [5:0] soft_int_number,
	input wire instr_done,
	input wire instr_start,
	input wire [19:0] instr_addr,
	input wire return_from_irq,
	// special sources
	input wire reset_pin_n,
	input wire nmi_enable,
	input wire nmi_pin_n,
	input wire debug_break_event,
	input wire watchdog_event,
	input wire osc_stop_event,
	input wire voltage_detect_event,
	input wire addr_match_enable,
	input wire [19:0] addr_match_reg,
	// peripheral sources
	input wire key_input_pin_n,
	input wire ext_irq_pin_zero,
	input wire ext_irq_pin_one,
	input wire ext_irq_pin_three,
	input wire ext_irq_pin_four,
	input wire ext_irq_pin_five,
	input wire [9:0] ext_edge_sel,
	input wire bus_collision_event,
	input wire [1:0] dma_event,
	input wire adc_event,
	input wire bus_negative_event,
	input wire bus_positive_event,
	input wire [3:0] uart_event,
	input wire [4:0] timer_a_event,
	input wire [2:0] timer_b_event,
	// priority fields, three bits per entry
	input wire [95:0] priority_level_field,
	input wire [31:0] request_clear,
	// break vector byte fetch
	input wire break_vec_valid,
	input wire [7:0] break_vec_byte,
	// vector fetch request and status
	output reg vec_fetch,
	output reg [19:0] vec_addr,
	output reg irq_taken,
	output reg stack_select,
	output reg [31:0] request_pending_bit,
	output reg break_wait
);
	// four bytes per vector, low byte first
	function [19:0] var_entry;
		input [19:0] base;
		input [5:0] num;
		begin
			var_entry = base + {12'h000, num, 2'b00};
		end
	endfunction
	function [2:0] lvl_of;
		input [95:0] f;
		input [4:0] n;
		begin
			lvl_of = f[n*3 +: 3];
		end
	endfunction

	wire [4:0] ext_hit;
	wire [31:0] raw_req;
	reg key_last;
	reg nmi_last;
	reg step_arm;
	reg saved_select;
	reg [31:0] next_pending;
	reg [19:0] next_addr;
	reg next_fetch;
	reg next_taken;
	reg next_break_wait;
	reg next_stack;
	reg [5:0] best_num;
	reg [2:0] best_lvl;
	reg best_ok;
	integer i;

	ext_edge_detect u_ext0 (.mclk(mclk), .arst_n(arst_n),
		.pin(ext_irq_pin_zero), .edge_sel(ext_edge_sel[1:0]),
		.hit(ext_hit[0]));
	ext_edge_detect u_ext1 (.mclk(mclk), .arst_n(arst_n),
		.pin(ext_irq_pin_one), .edge_sel(ext_edge_sel[3:2]),
		.hit(ext_hit[1]));
	ext_edge_detect u_ext3 (.mclk(mclk), .arst_n(arst_n),
		.pin(ext_irq_pin_three), .edge_sel(ext_edge_sel[5:4]),
		.hit(ext_hit[2]));
	ext_edge_detect u_ext4 (.mclk(mclk), .arst_n(arst_n),
		.pin(ext_irq_pin_four), .edge_sel(ext_edge_sel[7:6]),
		.hit(ext_hit[3]));
	ext_edge_detect u_ext5 (.mclk(mclk), .arst_n(arst_n),
		.pin(ext_irq_pin_five), .edge_sel(ext_edge_sel[9:8]),
		.hit(ext_hit[4]));

	// entry mapping of peripheral sources
	assign raw_req[0] = 1'b0;
	assign raw_req[3:1] = 3'h0;
	assign raw_req[`ENT_EXT3] = ext_hit[2];
	assign raw_req[7:5] = 3'h0;
	assign raw_req[`ENT_EXT5] = ext_hit[4];
	assign raw_req[`ENT_EXT4] = ext_hit[3];
	assign raw_req[`ENT_BUS_COLL] = bus_collision_event;
	assign raw_req[`ENT_DMA1:`ENT_DMA0] = dma_event;
	// level-low key pin; edge into low avoids re-requesting while held
	assign raw_req[`ENT_KEY] = ~key_input_pin_n & key_last;
	assign raw_req[`ENT_ADC] = adc_event;
	assign raw_req[15] = uart_event[0] | bus_negative_event;
	assign raw_req[16] = uart_event[1] | bus_positive_event;
	assign raw_req[20:17] = uart_event;
	assign raw_req[25:21] = timer_a_event;
	assign raw_req[28:26] = timer_b_event;
	assign raw_req[`ENT_EXT0] = ext_hit[0];
	assign raw_req[`ENT_EXT1] = ext_hit[1];
	assign raw_req[31] = 1'b0;

	// highest level pending maskable entry; ties go to lower number
	always @* begin
		best_num = 6'h00;
		best_lvl = `LEVEL_OFF;
		best_ok = 1'b0;
		for (i = 31; i >= 0; i = i - 1) begin
			if (request_pending_bit[i] &&
			    lvl_of(priority_level_field, i[4:0]) >= best_lvl &&
			    lvl_of(priority_level_field, i[4:0]) != `LEVEL_OFF) begin
				best_num = i[5:0];
				best_lvl = lvl_of(priority_level_field, i[4:0]);
				best_ok = 1'b1;
			end
		end
	end

	// source priority: reset, nmi, debug, watchdog, step, match,
	// instructions, then maskable
	always @* begin
		next_pending = request_pending_bit;
		next_fetch = 1'b0;
		next_taken = 1'b0;
		next_addr = vec_addr;
		next_break_wait = break_wait;
		next_stack = stack_select;
		if (break_wait) begin
			if (break_vec_valid) begin
				next_break_wait = 1'b0;
				if (break_vec_byte == `BREAK_REDIRECT) begin
					next_fetch = 1'b1;
					next_addr = var_entry(vector_base_reg, 6'h00);
				end
			end
		end else if (!reset_pin_n) begin
			next_fetch = 1'b1;
			next_taken = 1'b1;
			next_addr = `VEC_RESET;
		end else if (nmi_enable && !nmi_pin_n && nmi_last) begin
			next_fetch = 1'b1;
			next_taken = 1'b1;
			next_addr = `VEC_NMI;
		end else if (debug_break_event) begin
			next_fetch = 1'b1;
			next_taken = 1'b1;
			next_addr = `VEC_DEBUG;
		end else if (watchdog_event | osc_stop_event |
		             voltage_detect_event) begin
			next_fetch = 1'b1;
			next_taken = 1'b1;
			next_addr = `VEC_WDOG;
		end else if (step_arm) begin
			next_fetch = 1'b1;
			next_taken = 1'b1;
			next_addr = `VEC_STEP;
		end else if (addr_match_enable && instr_start &&
		             instr_addr == addr_match_reg) begin
			next_fetch = 1'b1;
			next_taken = 1'b1;
			next_addr = `VEC_ADDR_MATCH;
		end else if (undefined_opcode_instr) begin
			next_fetch = 1'b1;
			next_taken = 1'b1;
			next_addr = `VEC_UNDEF;
		end else if (overflow_trap_instr && overflow_flag) begin
			next_fetch = 1'b1;
			next_taken = 1'b1;
			next_addr = `VEC_OVFL;
		end else if (break_instr) begin
			next_fetch = 1'b1;
			next_taken = 1'b1;
			next_break_wait = 1'b1;
			next_addr = `VEC_BREAK;
		end else if (soft_int_instr) begin
			next_fetch = 1'b1;
			next_taken = 1'b1;
			next_addr = var_entry(vector_base_reg, soft_int_number);
			if (soft_int_number <= `VAR_PERIPH_LAST)
				next_stack = 1'b0;
			else
				next_stack = stack_select;
		end else if (global_irq_enable && best_ok &&
		             best_lvl > cpu_priority_level) begin
			next_fetch = 1'b1;
			next_taken = 1'b1;
			next_addr = var_entry(vector_base_reg, best_num);
			next_stack = 1'b0;
			next_pending[best_num[4:0]] = 1'b0;
		end else if (return_from_irq) begin
			next_stack = saved_select;
		end
		// software clear first, then new events win
		next_pending = (next_pending & ~request_clear) |
			(raw_req & ~`RESERVED_MASK);
	end

	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			request_pending_bit <= 32'h00000000;
			vec_fetch <= 1'b0;
			vec_addr <= `VEC_RESET;
			irq_taken <= 1'b0;
			stack_select <= 1'b0;
			saved_select <= 1'b0;
			break_wait <= 1'b0;
			key_last <= 1'b1;
			nmi_last <= 1'b1;
			step_arm <= 1'b0;
		end else begin
			request_pending_bit <= next_pending;
			vec_fetch <= next_fetch;
			vec_addr <= next_addr;
			irq_taken <= next_taken;
			break_wait <= next_break_wait;
			key_last <= key_input_pin_n;
			nmi_last <= nmi_pin_n;
			if (next_taken)
				saved_select <= stack_select_flag;
			// track cpu flag unless this block overrides it
			if (next_stack != stack_select || next_taken)
				stack_select <= next_stack;
			else
				stack_select <= stack_select_flag;
			// held one cycle so step follows completion
			if (next_taken && next_addr == `VEC_STEP)
				step_arm <= 1'b0;
			else if (debug_flag && instr_done)
				step_arm <= 1'b1;
		end
	end
endmodule

// [dv/interrupt_vectoring_unit_chk.sv]
`timescale 1ns/100ps
module interrupt_vectoring_unit_chk (
	// clock and reset
	input wire mclk,
	input wire arst_n,
	// inputs seen
	input wire reset_pin_n,
	input wire global_irq_enable,
	input wire overflow_flag,
	input wire stack_select_flag,
	input wire [19:0] vector_base_reg,
	input wire undefined_opcode_instr,
	input wire overflow_trap_instr,
	input wire break_instr,
	input wire soft_int_instr,
	input wire [5:0] soft_int_number,
	input wire adc_event,
	input wire break_vec_valid,
	input wire [7:0] break_vec_byte,
	// outputs seen
	input wire vec_fetch,
	input wire [19:0] vec_addr,
	input wire stack_select,
	input wire [31:0] request_pending_bit,
	input wire break_wait
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	// a pending break or reset pin drops other sources
	wire quiet = reset_pin_n && !break_wait;
	sequence s_brk_req;
		break_instr && quiet;
	endsequence
	sequence s_brk_red;
		break_wait && break_vec_valid && break_vec_byte == 8'hFF;
	endsequence
	a_undef_vec: assert property (
		undefined_opcode_instr && quiet |=> vec_addr == 20'hFFFDC)
		else $error("bad undef vector");
	a_ovfl_skip: assert property (
		overflow_trap_instr && !overflow_flag && quiet |=> !vec_fetch)
		else $error("overflow trap taken");
	a_break_wait: assert property (s_brk_req |=>
		break_wait && vec_addr == 20'hFFFE4) else $error("bad break");
	a_break_redir: assert property (s_brk_red |=>
		vec_fetch && !break_wait && vec_addr == $past(vector_base_reg))
		else $error("bad break redirect");
	a_soft_low: assert property (
		soft_int_instr && quiet && !soft_int_number[5] |=> !stack_select
		&& vec_addr == $past(vector_base_reg)
		+ {12'h000, $past(soft_int_number), 2'h0}) else $error("bad soft");
	a_soft_high: assert property (
		soft_int_instr && quiet && soft_int_number[5] |=> vec_fetch
		&& stack_select == $past(stack_select_flag))
		else $error("bad soft high");
	a_reset_pin: assert property (
		!reset_pin_n |=> vec_addr == 20'hFFFFC) else $error("bad reset");
	a_pend_set: assert property (
		adc_event |=> request_pending_bit[14]) else $error("no pending");
	a_mask_block: assert property (
		!global_irq_enable && request_pending_bit[14] |=> !vec_fetch)
		else $error("masked request taken");
endmodule
bind interrupt_vectoring_unit interrupt_vectoring_unit_chk u_chk (.*);

// [dv/vector_memory_model.sv]
`timescale 1ns/100ps
module vector_memory_model (
	// clock and fetch state
	input wire mclk,
	input wire break_wait,
	// answer delay and vector byte
	input wire [3:0] lag,
	input wire [7:0] fill,
	output logic break_vec_valid,
	output logic [7:0] break_vec_byte
);
	logic [3:0] cnt = 4'h0;
	initial break_vec_valid = 1'b0;
	initial break_vec_byte = 8'h00;
	// undriven bus between answers, so the byte keeps flipping
	always @(negedge mclk) begin
		cnt <= break_wait ? cnt + 4'h1 : 4'h0;
		break_vec_valid <= break_wait && cnt == lag;
		break_vec_byte <= break_wait && cnt == lag ? fill : ~break_vec_byte;
	end
endmodule

// [dv/interrupt_vectoring_unit_tb.sv]
`timescale 1ns/100ps
module interrupt_vectoring_unit_tb;
	logic mclk, arst_n, global_irq_enable, overflow_flag, debug_flag;
	logic stack_select_flag, undefined_opcode_instr, overflow_trap_instr;
	logic break_instr, soft_int_instr, instr_done, instr_start;
	logic return_from_irq, reset_pin_n, nmi_enable, nmi_pin_n;
	logic debug_break_event, watchdog_event, osc_stop_event;
	logic voltage_detect_event, addr_match_enable, key_input_pin_n;
	logic ext_irq_pin_zero, ext_irq_pin_one, ext_irq_pin_three;
	logic ext_irq_pin_four, ext_irq_pin_five, bus_collision_event;
	logic adc_event, bus_negative_event, bus_positive_event;
	logic break_vec_valid, vec_fetch, irq_taken, stack_select, break_wait;
	logic [1:0] dma_event;
	logic [2:0] cpu_priority_level, timer_b_event;
	logic [3:0] uart_event, lag;
	logic [4:0] timer_a_event, pins;
	logic [5:0] soft_int_number;
	logic [7:0] break_vec_byte, spec, fill;
	logic [9:0] ext_edge_sel;
	logic [17:0] periph;
	logic [19:0] vector_base_reg, instr_addr, addr_match_reg, vec_addr;
	logic [31:0] request_clear, request_pending_bit;
	logic [95:0] priority_level_field;
	int err_count = 0;
	int check_count = 0;
	logic [19:0] fixed_vec [8] = '{20'hFFFDC, 20'hFFFE0, 20'hFFFF4,
		20'hFFFF0, 20'hFFFF0, 20'hFFFF0, 20'hFFFEC, 20'hFFFE8};
	int pin_ent [5] = '{29, 30, 4, 9, 8};
	assign {instr_start, instr_done, voltage_detect_event, osc_stop_event,
		watchdog_event, debug_break_event, overflow_trap_instr,
		undefined_opcode_instr} = spec;
	assign {timer_b_event, timer_a_event, uart_event, bus_positive_event,
		bus_negative_event, adc_event, dma_event, bus_collision_event} = periph;
	assign {ext_irq_pin_five, ext_irq_pin_four, ext_irq_pin_three,
		ext_irq_pin_one, ext_irq_pin_zero} = pins;
	interrupt_vectoring_unit u_dut (.*);
	vector_memory_model u_mem (.*);
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic tick(int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic clr;
		request_clear = '1;
		tick(1);
		request_clear = '0;
		tick(1);
	endtask
	task automatic poll(int b);
		for (int n = 0; n < 4 && request_pending_bit[b] !== 1'b1; n++)
			tick(1);
	endtask
	task automatic t_fixed;
		{overflow_flag, debug_flag} = 2'h3;
		for (int i = 0; i < 9; i++) begin
			spec = i < 8 ? 8'h01 << i : 8'h00;
			nmi_pin_n = i < 8;
			tick(1);
			// step waits one cycle for completion, others answer at once
			chk(vec_fetch, i != 6);
			{spec, nmi_pin_n} = 9'h001;
			tick(1);
			chk(vec_fetch, i == 6);
			chk(vec_addr, i < 8 ? fixed_vec[i] : 20'hFFFF8);
		end
		{overflow_flag, debug_flag} = 2'h0;
		instr_addr = 20'h00101;
		spec = 8'h82;
		tick(1);
		chk(vec_fetch, 1'b0);
		spec = 8'h00;
		tick(1);
		instr_addr = 20'h00100;
		reset_pin_n = 1'b0;
		tick(2);
		chk(vec_addr, 20'hFFFFC);
		reset_pin_n = 1'b1;
		tick(2);
		$display("fixed test done");
	endtask
	task automatic t_break(logic [3:0] l);
		{lag, fill} = {l, 8'hFF};
		break_instr = 1'b1;
		tick(1);
		chk({vec_fetch, break_wait, vec_addr}, {2'h3, 20'hFFFE4});
		break_instr = 1'b0;
		// undefined opcode while waiting must be ignored
		spec = {7'h00, l != 4'h0};
		tick(1);
		spec = 8'h00;
		for (int n = 0; n < 20 && vec_fetch !== 1'b1; n++)
			tick(1);
		chk({vec_fetch, irq_taken, break_wait, vec_addr},
			{3'h4, vector_base_reg});
		$display("break test done");
	endtask
	task automatic t_soft;
		for (int k = 0; k < 4; k++) begin
			soft_int_number = {k[1], {5{k[0]}}};
			soft_int_instr = 1'b1;
			tick(1);
			chk(vec_addr, vector_base_reg + 20'h4 * soft_int_number);
			chk(stack_select, soft_int_number[5]);
			soft_int_instr = 1'b0;
			return_from_irq = !soft_int_number[5];
			tick(1);
			return_from_irq = 1'b0;
			tick(1);
			chk(stack_select, 1'b1);
		end
		$display("soft test done");
	endtask
	task automatic t_periph;
		for (int i = 0; i < 18; i++) begin
			periph = 18'h1 << i;
			tick(1);
			periph = '0;
			tick(1);
			chk(request_pending_bit[i < 3 ? 10 + i : 11 + i], 1'b1);
			chk(request_pending_bit & 32'h800000EF, 32'h0);
			clr;
			chk(request_pending_bit, 32'h0);
		end
		ext_edge_sel = 10'h2AA;
		for (int k = 0; k < 10; k++) begin
			pins = k[0] ? 5'h00 : 5'h01 << k / 2;
			poll(pin_ent[k / 2]);
			chk(request_pending_bit[pin_ent[k / 2]], 1'b1);
			clr;
		end
		key_input_pin_n = 1'b0;
		poll(13);
		chk(request_pending_bit[13], 1'b1);
		key_input_pin_n = 1'b1;
		clr;
		$display("peripheral test done");
	endtask
	task automatic t_mask;
		priority_level_field[44:42] = 3'h3;
		cpu_priority_level = 3'h3;
		periph = 18'h8;
		tick(1);
		periph = '0;
		tick(4);
		chk(request_pending_bit[14], 1'b1);
		global_irq_enable = 1'b1;
		tick(3);
		chk(request_pending_bit[14], 1'b1);
		cpu_priority_level = 3'h2;
		for (int n = 0; n < 4 && vec_fetch !== 1'b1; n++)
			tick(1);
		chk({vec_fetch, request_pending_bit[14], vec_addr},
			{2'h2, vector_base_reg + 20'h38});
		{priority_level_field[44:42], cpu_priority_level} = 6'h00;
		periph = 18'h8;
		tick(1);
		periph = '0;
		tick(4);
		chk(request_pending_bit[14], 1'b1);
		global_irq_enable = 1'b0;
		clr;
		$display("mask test done");
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#(20 * 4000);
		err_count++;
		tally_and_finish;
	end
	initial begin
		{global_irq_enable, overflow_flag, debug_flag, break_instr,
			soft_int_instr, return_from_irq, spec, periph, pins,
			request_clear, priority_level_field, soft_int_number,
			cpu_priority_level, ext_edge_sel, lag, fill, arst_n} = '0;
		{stack_select_flag, reset_pin_n, nmi_enable, nmi_pin_n} = 4'hF;
		{addr_match_enable, key_input_pin_n} = 2'h3;
		vector_base_reg = 20'h40000;
		addr_match_reg = 20'h00100;
		instr_addr = 20'h00100;
		tick(4);
		chk(vec_addr, 20'hFFFFC);
		tick(4);
		arst_n = 1'b1;
		tick(2);
		t_fixed;
		t_break(4'h0);
		t_break(4'h5);
		t_soft;
		t_periph;
		t_mask;
		tally_and_finish;
	end
endmodule
